// file: src/rtb_regs.svh
`ifndef RTB_REGS_SVH
`define RTB_REGS_SVH

`define RTB_OFS_DEST_SEL 24'h00_0070
`define RTB_OFS_PORT_SEL 24'h00_0074
`define RTB_OFS_DEF_PORT 24'h00_0078
`define RTB_OFS_LOCAL_SEL 24'h00_1070
`define RTB_OFS_DOMAIN 24'hF2_0020
`define RTB_OFS_GLB_DEV 24'hE0_0000
`define RTB_OFS_LOC_DEV 24'hE1_0000
`define RTB_LOC_PORT_LSB 12

`define RTB_ENT_DEFAULT 8'hDE
`define RTB_ENT_NOROUTE 8'hDF
`define RTB_ENT_FORCE_LOCAL 8'hDD
`define RTB_REGION_PORT 2'h0
`define RTB_REGION_MCAST 2'h1

`define RTB_TT_8BIT 2'h0
`define RTB_TT_16BIT 2'h1

`define RTB_LSEL_LOCAL_BIT 8
`define RTB_DEF_PORT_RESET 8'h00
`define RTB_DOMAIN_RESET 8'h00
`define RTB_DEST_SEL_RESET 16'h0000
`define RTB_BLK_LAST 2'h3

`endif

// file: src/rtb_pkg.sv
`default_nettype none
package rtb_pkg;

  typedef enum logic [1:0] {
    RTB_FWD_UNICAST = 2'b00,
    RTB_FWD_MCAST = 2'b01,
    RTB_FWD_DISCARD = 2'b10,
    RTB_FWD_TERMINATE = 2'b11
  } rtb_fwd_e;

  typedef enum logic [0:0] {
    RTB_ST_IDLE = 1'b0,
    RTB_ST_BLOCK = 1'b1
  } rtb_state_e;

  typedef struct packed {
    logic [1:0] tt;
    logic maint;
    logic [7:0] hop;
    logic [15:0] dest_id;
  } rtb_lkup_req_s;

  typedef struct packed {
    rtb_fwd_e kind;
    logic [3:0] port;
    logic [3:0] mask;
  } rtb_lkup_res_s;

  typedef struct packed {
    logic wr;
    logic blk;
    logic [23:0] addr;
    logic [31:0] wdata;
  } rtb_cfg_req_s;

  typedef struct packed {
    logic en;
    logic glob;
    logic dom;
    logic [3:0] port;
    logic [7:0] idx;
    logic [7:0] data;
  } rtb_tbl_wr_s;

  function automatic logic rtb_in_domain(input logic [7:0] upper,
                                         input logic [7:0] dom);
    return (upper == 8'h00) || (upper == dom);
  endfunction

endpackage
`default_nettype wire

// file: src/rtb_table_bank.sv
`include "rtb_regs.svh"
`default_nettype none
module rtb_table_bank #(
  parameter int DEPTH = 256,
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VAL = `RTB_ENT_DEFAULT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx_a,
  output logic [WIDTH-1:0] rd_data_a,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx_b,
  output logic [WIDTH-1:0] rd_data_b
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("rtb_table_bank: DEPTH and WIDTH out of range");
  end

  // Whole entry written in one edge, readers never see half a value
  for (genvar i = 0; i < DEPTH; i++) begin : g_ent
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        mem[i] <= RESET_VAL;
      end else if (wr_en && wr_idx == AW'(i)) begin
        mem[i] <= wr_data;
      end
    end
  end

  assign rd_data_a = mem[rd_idx_a];
  assign rd_data_b = mem[rd_idx_b];

endmodule
`default_nettype wire

// file: src/rtb_lookup.sv
`include "rtb_regs.svh"
`default_nettype none
module rtb_lookup #(
  parameter int NPORTS = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire rtb_pkg::rtb_lkup_req_s req,
  input wire logic [7:0] domain_val,
  input wire logic [7:0] def_port,
  output logic [7:0] dom_idx,
  output logic [7:0] dev_idx,
  input wire logic [7:0] dom_entry,
  input wire logic [7:0] dev_entry,
  output logic res_valid,
  output rtb_pkg::rtb_lkup_res_s res
);
  import rtb_pkg::*;

  logic use_dom;
  logic [7:0] entry;
  rtb_lkup_res_s res_next;

  if (NPORTS < 1 || NPORTS > 16) begin : g_bad
    $error("rtb_lookup: NPORTS must be 1 to 16");
  end

  // Domain byte above, device byte below; 8-bit IDs sit in the low byte
  assign dom_idx = req.dest_id[15:8];
  assign dev_idx = req.dest_id[7:0];
  assign use_dom = (req.tt == `RTB_TT_16BIT) &&
                   !rtb_in_domain(req.dest_id[15:8], domain_val);

  always_comb begin
    entry = dev_entry;
    if (use_dom && dom_entry != `RTB_ENT_FORCE_LOCAL) begin
      entry = dom_entry;
    end
    // Force-local falls through to the device entry already chosen
    res_next = '{kind: RTB_FWD_DISCARD, port: 4'h0, mask: 4'h0};
    if (entry == `RTB_ENT_DEFAULT) begin
      res_next.kind = RTB_FWD_UNICAST;
      res_next.port = def_port[3:0];
    end else if (entry[7:6] == `RTB_REGION_PORT && entry[5:4] == 2'h0 &&
                 32'(entry[3:0]) < NPORTS) begin
      res_next.kind = RTB_FWD_UNICAST;
      res_next.port = entry[3:0];
    end else if (entry[7:6] == `RTB_REGION_MCAST && entry[5:4] == 2'h0) begin
      res_next.kind = RTB_FWD_MCAST;
      res_next.mask = entry[3:0];
    end
    // No-route, force-local in the device table and odd codes drop
    if (req.tt != `RTB_TT_8BIT && req.tt != `RTB_TT_16BIT) begin
      res_next = '{kind: RTB_FWD_DISCARD, port: 4'h0, mask: 4'h0};
    end else if (req.maint && req.hop == 8'h00) begin
      res_next = '{kind: RTB_FWD_TERMINATE, port: 4'h0, mask: 4'h0};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      res_valid <= 1'b0;
    end else begin
      res_valid <= req_valid;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      res <= '{kind: RTB_FWD_DISCARD, port: 4'h0, mask: 4'h0};
    end else if (req_valid) begin
      res <= res_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_noroute_discard: assert property (
    req_valid && req.tt == `RTB_TT_8BIT && !req.maint &&
    dev_entry == `RTB_ENT_NOROUTE
    |=> res_valid && res.kind == RTB_FWD_DISCARD)
    else $error("no-route entry was not discarded");

  a_force_local_dev: assert property (
    req_valid && !req.maint && use_dom &&
    dom_entry == `RTB_ENT_FORCE_LOCAL && dev_entry[7:4] == 4'h0 &&
    32'(dev_entry[3:0]) < NPORTS
    |=> res.kind == RTB_FWD_UNICAST && res.port == $past(dev_entry[3:0]))
    else $error("force-local did not use the device entry");

  a_default_port: assert property (
    req_valid && !req.maint && req.tt == `RTB_TT_8BIT &&
    dev_entry == `RTB_ENT_DEFAULT
    |=> res.kind == RTB_FWD_UNICAST && res.port == $past(def_port[3:0]))
    else $error("default route did not use default port");

  a_hop_forward: assert property (
    req_valid && req.maint && req.hop != 8'h00 &&
    req.tt == `RTB_TT_8BIT && dev_entry[7:4] == 4'h0 &&
    32'(dev_entry[3:0]) < NPORTS
    |=> res.kind == RTB_FWD_UNICAST && res.port == $past(dev_entry[3:0]))
    else $error("hop-count packet not forwarded by local table");

endmodule
`default_nettype wire

// file: src/rtb_route_table.sv
`include "rtb_regs.svh"
`default_nettype none
module rtb_route_table #(
  parameter int NPORTS = 16
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic cfg_valid,
  input wire rtb_pkg::rtb_cfg_req_s cfg_req,
  output logic cfg_ready,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic [NPORTS-1:0] lk_valid,
  input wire rtb_pkg::rtb_lkup_req_s lk_req [NPORTS],
  output logic [NPORTS-1:0] lk_res_valid,
  output rtb_pkg::rtb_lkup_res_s lk_res [NPORTS]
);
  import rtb_pkg::*;

  localparam logic [23:0] GLB_BASE = `RTB_OFS_GLB_DEV;
  localparam logic [23:0] LOC_BASE = `RTB_OFS_LOC_DEV;

  if (NPORTS < 1 || NPORTS > 16) begin : g_bad
    $error("rtb_route_table: NPORTS must be 1 to 16");
  end

  logic [15:0] dest_sel_reg;
  logic [8:0] lsel_reg;
  logic [7:0] domain_reg;
  logic [7:0] def_port_reg;
  rtb_state_e state_reg;
  logic [1:0] cnt_reg;
  logic [31:0] blk_word_reg;
  logic ack_next;
  logic [31:0] rdata_next;
  logic acc;
  logic in_dom;
  logic start_blk;
  logic hit_glb_dir;
  logic hit_loc_dir;
  logic [3:0] dir_port;
  logic [3:0] rd_port;
  logic rd_port_ok;
  logic [7:0] rd_idx;
  logic [7:0] sel_idx;
  rtb_tbl_wr_s tw;
  logic [7:0] gdom_rd;
  logic [7:0] gdev_rd;
  logic [7:0] ldom_rd [NPORTS];
  logic [7:0] ldev_rd [NPORTS];
  logic [7:0] lk_dom_idx [NPORTS];
  logic [7:0] lk_dev_idx [NPORTS];
  logic [7:0] lk_dom_ent [NPORTS];
  logic [7:0] lk_dev_ent [NPORTS];

  assign cfg_ready = (state_reg == RTB_ST_IDLE);
  assign acc = cfg_valid && cfg_ready;
  // Own domain or zero selects the device table, else the domain table
  assign in_dom = rtb_in_domain(dest_sel_reg[15:8], domain_reg);
  assign sel_idx = in_dom ? dest_sel_reg[7:0] : dest_sel_reg[15:8];
  assign start_blk = acc && cfg_req.wr && cfg_req.blk && in_dom &&
                     cfg_req.addr == `RTB_OFS_PORT_SEL;
  assign hit_glb_dir = cfg_req.addr[23:10] == GLB_BASE[23:10];
  assign hit_loc_dir = cfg_req.addr[23:16] == LOC_BASE[23:16] &&
                       cfg_req.addr[11:10] == 2'h0;
  assign dir_port = cfg_req.addr[`RTB_LOC_PORT_LSB +: 4];

  // Registers written by the configuration agent
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dest_sel_reg <= `RTB_DEST_SEL_RESET;
    end else if (acc && cfg_req.wr &&
                 cfg_req.addr == `RTB_OFS_DEST_SEL) begin
      dest_sel_reg <= cfg_req.wdata[15:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lsel_reg <= 9'h000;
    end else if (acc && cfg_req.wr &&
                 cfg_req.addr == `RTB_OFS_LOCAL_SEL) begin
      lsel_reg <= {cfg_req.wdata[`RTB_LSEL_LOCAL_BIT], 4'h0,
                   cfg_req.wdata[3:0]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      domain_reg <= `RTB_DOMAIN_RESET;
    end else if (acc && cfg_req.wr && cfg_req.addr == `RTB_OFS_DOMAIN) begin
      domain_reg <= cfg_req.wdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      def_port_reg <= `RTB_DEF_PORT_RESET;
    end else if (acc && cfg_req.wr &&
                 cfg_req.addr == `RTB_OFS_DEF_PORT) begin
      def_port_reg <= cfg_req.wdata[7:0];
    end
  end

  // Block sequencer: first entry goes out on the accept cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= RTB_ST_IDLE;
      cnt_reg <= 2'h0;
    end else begin
      case (state_reg)
        RTB_ST_IDLE: begin
          if (start_blk) begin
            state_reg <= RTB_ST_BLOCK;
            cnt_reg <= 2'h1;
          end
        end
        RTB_ST_BLOCK: begin
          cnt_reg <= cnt_reg + 2'h1;
          if (cnt_reg == `RTB_BLK_LAST) begin
            state_reg <= RTB_ST_IDLE;
          end
        end
        default: begin
          state_reg <= RTB_ST_IDLE;
          cnt_reg <= 2'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blk_word_reg <= 32'h0000_0000;
    end else if (start_blk) begin
      blk_word_reg <= cfg_req.wdata;
    end
  end

  // One table write per cycle; a global one lands in all locals too
  always_comb begin
    tw = '0;
    if (state_reg == RTB_ST_BLOCK) begin
      tw.en = 1'b1;
      tw.glob = !lsel_reg[`RTB_LSEL_LOCAL_BIT];
      tw.port = lsel_reg[3:0];
      // Only the low byte counts, so the domain byte never carries
      tw.idx = dest_sel_reg[7:0] + {6'h00, cnt_reg};
      tw.data = blk_word_reg[{cnt_reg, 3'h0} +: 8];
    end else if (acc && cfg_req.wr) begin
      if (cfg_req.addr == `RTB_OFS_PORT_SEL) begin
        tw.en = 1'b1;
        tw.glob = !lsel_reg[`RTB_LSEL_LOCAL_BIT];
        tw.port = lsel_reg[3:0];
        tw.dom = !in_dom;
        tw.idx = sel_idx;
        tw.data = cfg_req.wdata[7:0];
      end else if (hit_glb_dir) begin
        tw.en = 1'b1;
        tw.glob = 1'b1;
        tw.idx = cfg_req.addr[9:2];
        tw.data = cfg_req.wdata[7:0];
      end else if (hit_loc_dir) begin
        tw.en = 1'b1;
        tw.port = dir_port;
        tw.idx = cfg_req.addr[9:2];
        tw.data = cfg_req.wdata[7:0];
      end
    end
  end

  // Read side shares index and port selection with the write side
  always_comb begin
    rd_idx = sel_idx;
    rd_port = lsel_reg[3:0];
    if (cfg_req.addr != `RTB_OFS_PORT_SEL) begin
      rd_idx = cfg_req.addr[9:2];
      rd_port = dir_port;
    end
  end
  assign rd_port_ok = 32'(rd_port) < NPORTS;

  rtb_table_bank #(.DEPTH(256), .WIDTH(8), .RESET_VAL(`RTB_ENT_DEFAULT))
    u_gdom (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(tw.en && tw.glob && tw.dom),
    .wr_idx(tw.idx),
    .wr_data(tw.data),
    .rd_idx_a(rd_idx),
    .rd_data_a(gdom_rd),
    .rd_idx_b(rd_idx),
    .rd_data_b()
  );

  rtb_table_bank #(.DEPTH(256), .WIDTH(8), .RESET_VAL(`RTB_ENT_DEFAULT))
    u_gdev (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_en(tw.en && tw.glob && !tw.dom),
    .wr_idx(tw.idx),
    .wr_data(tw.data),
    .rd_idx_a(rd_idx),
    .rd_data_a(gdev_rd),
    .rd_idx_b(rd_idx),
    .rd_data_b()
  );

  for (genvar p = 0; p < NPORTS; p++) begin : g_port
    logic sel_me;
    // Global and local share the one write slot, so order decides
    assign sel_me = tw.en && (tw.glob || tw.port == 4'(p));

    rtb_table_bank #(.DEPTH(256), .WIDTH(8), .RESET_VAL(`RTB_ENT_DEFAULT))
      u_dom (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wr_en(sel_me && tw.dom),
      .wr_idx(tw.idx),
      .wr_data(tw.data),
      .rd_idx_a(lk_dom_idx[p]),
      .rd_data_a(lk_dom_ent[p]),
      .rd_idx_b(rd_idx),
      .rd_data_b(ldom_rd[p])
    );

    rtb_table_bank #(.DEPTH(256), .WIDTH(8), .RESET_VAL(`RTB_ENT_DEFAULT))
      u_dev (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .wr_en(sel_me && !tw.dom),
      .wr_idx(tw.idx),
      .wr_data(tw.data),
      .rd_idx_a(lk_dev_idx[p]),
      .rd_data_a(lk_dev_ent[p]),
      .rd_idx_b(rd_idx),
      .rd_data_b(ldev_rd[p])
    );

    rtb_lookup #(.NPORTS(NPORTS)) u_lookup (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .req_valid(lk_valid[p]),
      .req(lk_req[p]),
      .domain_val(domain_reg),
      .def_port(def_port_reg),
      .dom_idx(lk_dom_idx[p]),
      .dev_idx(lk_dev_idx[p]),
      .dom_entry(lk_dom_ent[p]),
      .dev_entry(lk_dev_ent[p]),
      .res_valid(lk_res_valid[p]),
      .res(lk_res[p])
    );
  end

  // Unmapped addresses read as zero and ignore writes
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (cfg_req.addr == `RTB_OFS_DEST_SEL) begin
      rdata_next = {16'h0000, dest_sel_reg};
    end else if (cfg_req.addr == `RTB_OFS_LOCAL_SEL) begin
      rdata_next = {23'h00_0000, lsel_reg};
    end else if (cfg_req.addr == `RTB_OFS_DOMAIN) begin
      rdata_next = {24'h00_0000, domain_reg};
    end else if (cfg_req.addr == `RTB_OFS_DEF_PORT) begin
      rdata_next = {24'h00_0000, def_port_reg};
    end else if (cfg_req.addr == `RTB_OFS_PORT_SEL) begin
      if (!lsel_reg[`RTB_LSEL_LOCAL_BIT]) begin
        rdata_next = {24'h00_0000, in_dom ? gdev_rd : gdom_rd};
      end else if (rd_port_ok) begin
        rdata_next = {24'h00_0000,
                      in_dom ? ldev_rd[rd_port] : ldom_rd[rd_port]};
      end
    end else if (hit_glb_dir) begin
      rdata_next = {24'h00_0000, gdev_rd};
    end else if (hit_loc_dir && rd_port_ok) begin
      rdata_next = {24'h00_0000, ldev_rd[rd_port]};
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h0000_0000;
    end else if (acc && !cfg_req.wr) begin
      cfg_rdata <= rdata_next;
    end
  end

  // A block write answers only after its last entry is written
  assign ack_next = (acc && !start_blk) ||
                    (state_reg == RTB_ST_BLOCK && cnt_reg == `RTB_BLK_LAST);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ack <= 1'b0;
    end else begin
      cfg_ack <= ack_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_block_beats;
    (state_reg == RTB_ST_BLOCK && !cfg_ready)[*3];
  endsequence

  sequence s_block_done;
    state_reg == RTB_ST_IDLE && cfg_ack;
  endsequence

  a_block_four: assert property (
    start_blk |=> s_block_beats ##1 s_block_done)
    else $error("block write did not take four cycles");

  a_block_wrap: assert property (
    start_blk |-> ##3 (tw.en && !tw.dom &&
                       tw.idx == dest_sel_reg[7:0] + 8'h03))
    else $error("block write index left its domain");

  a_domain_single: assert property (
    acc && cfg_req.wr && cfg_req.blk && !in_dom &&
    cfg_req.addr == `RTB_OFS_PORT_SEL
    |-> tw.dom ##1 (state_reg == RTB_ST_IDLE && cfg_ack))
    else $error("foreign block write did more than one entry");

  a_glob_replicate: assert property (
    tw.en && tw.glob && !tw.dom
    |=> g_port[0].u_dev.mem[$past(tw.idx)] == $past(tw.data))
    else $error("global write not copied to local table");

  a_local_isolate: assert property (
    tw.en && !tw.glob && !tw.dom
    |=> u_gdev.mem[$past(tw.idx)] == $past(u_gdev.mem[tw.idx]))
    else $error("local write changed the global table");

  a_read_answer: assert property (
    acc && !cfg_req.wr && cfg_req.addr == `RTB_OFS_DOMAIN
    |=> cfg_ack && cfg_rdata == {24'h00_0000, domain_reg})
    else $error("register read answer wrong");

endmodule
`default_nettype wire

// file: bench/rtb_agent.sv
`default_nettype none
module rtb_agent (
  input wire logic clk_sys,
  output var logic cfg_valid,
  output var rtb_pkg::rtb_cfg_req_s cfg_req,
  input wire logic cfg_ready,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  import rtb_pkg::*;

  initial begin
    cfg_valid = 1'b0;
    cfg_req = '0;
  end

  // Held until a ready edge takes it; dropped on that same edge
  task xfer(input rtb_cfg_req_s r, output logic [31:0] d);
    int n;
    @(posedge clk_sys);
    cfg_valid <= 1'b1;
    cfg_req <= r;
    #1;
    for (n = 0; n < 20 && cfg_ready !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    @(posedge clk_sys);
    cfg_valid <= 1'b0;
    // Released fields flip so stale values cannot pass
    cfg_req <= ~r;
    #1;
    for (n = 0; n < 20 && cfg_ack !== 1'b1; n++) begin
      @(posedge clk_sys);
      #1;
    end
    d = (cfg_ack === 1'b1) ? cfg_rdata : 32'hxxxx_xxxx;
  endtask
endmodule
`default_nettype wire

// file: bench/rtb_route_table_test.sv
`include "rtb_regs.svh"
`default_nettype none
module rtb_route_table_test;
  timeunit 1ns;
  timeprecision 1ns;
  import rtb_pkg::*;
  localparam rtb_fwd_e UC = RTB_FWD_UNICAST;
  localparam rtb_fwd_e MC = RTB_FWD_MCAST;
  localparam rtb_fwd_e DS = RTB_FWD_DISCARD;
  localparam rtb_fwd_e TM = RTB_FWD_TERMINATE;
  localparam logic [23:0] DSEL = `RTB_OFS_DEST_SEL;
  localparam logic [23:0] PSEL = `RTB_OFS_PORT_SEL;
  localparam logic [23:0] LSEL = `RTB_OFS_LOCAL_SEL;
  localparam logic [23:0] DOM = `RTB_OFS_DOMAIN;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic cfg_valid;
  logic cfg_ready;
  logic cfg_ack;
  rtb_cfg_req_s cfg_req;
  logic [31:0] cfg_rdata;
  logic [15:0] lk_valid = 16'h0000;
  rtb_lkup_req_s lk_req [16];
  logic [15:0] lk_res_valid;
  rtb_lkup_res_s lk_res [16];
  int miscompares = 0;
  int cmp_count = 0;

  always #25 clk_sys = ~clk_sys;

  rtb_agent agent_u (
    .clk_sys(clk_sys),
    .cfg_valid(cfg_valid),
    .cfg_req(cfg_req),
    .cfg_ready(cfg_ready),
    .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata)
  );

  rtb_route_table #(.NPORTS(16)) dut_u (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .cfg_valid(cfg_valid),
    .cfg_req(cfg_req),
    .cfg_ready(cfg_ready),
    .cfg_ack(cfg_ack),
    .cfg_rdata(cfg_rdata),
    .lk_valid(lk_valid),
    .lk_req(lk_req),
    .lk_res_valid(lk_res_valid),
    .lk_res(lk_res)
  );

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task close_out();
    $display("miscompares %0d cmp_count %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task wr(logic [23:0] a, logic [31:0] d, logic b = 1'b0);
    logic [31:0] x;
    agent_u.xfer('{1'b1, b, a, d}, x);
  endtask

  task rd(logic [23:0] a, logic [31:0] e);
    logic [31:0] x;
    agent_u.xfer('{1'b0, 1'b0, a, 32'h0000_0000}, x);
    chk(x, e);
  endtask

  // Only the field that the kind gives meaning to is compared
  task look(int p, logic [1:0] tt, logic [8:0] mh, logic [15:0] id,
            rtb_fwd_e k, logic [3:0] v);
    logic [3:0] s;
    @(posedge clk_sys);
    lk_valid[p] <= 1'b1;
    lk_req[p] <= '{tt, mh[8], mh[7:0], id};
    @(posedge clk_sys);
    lk_valid[p] <= 1'b0;
    #1;
    s = (k == UC) ? lk_res[p].port : (k == MC) ? lk_res[p].mask : 4'h0;
    chk({lk_res_valid[p], lk_res[p].kind, s}, {1'b1, k, v});
  endtask

  task lk8(int p, logic [15:0] id, rtb_fwd_e k, logic [3:0] v);
    look(p, 2'h0, 9'h000, id, k, v);
  endtask

  task lk16(int p, logic [15:0] id, rtb_fwd_e k, logic [3:0] v);
    look(p, 2'h1, 9'h000, id, k, v);
  endtask

  initial begin
    repeat (4000) @(posedge clk_sys);
    miscompares++;
    close_out();
  end

  initial begin
    foreach (lk_req[i]) lk_req[i] = '0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    lk8(0, 8'h05, UC, 4'h0);
    lk16(15, 16'h3405, UC, 4'h0);
    rd(24'hE0_0014, 8'hDE);
    rd(DSEL, 8'h00);
    rd(DOM, 8'h00);
    wr(DSEL, 8'h05);
    wr(PSEL, 8'h03);
    rd(PSEL, 8'h03);
    lk8(0, 8'h05, UC, 4'h3);
    lk8(15, 8'h05, UC, 4'h3);
    wr(LSEL, 16'h0102);
    rd(LSEL, 16'h0102);
    wr(PSEL, 8'h07);
    rd(PSEL, 8'h07);
    lk8(2, 8'h05, UC, 4'h7);
    lk8(1, 8'h05, UC, 4'h3);
    rd(24'hE0_0014, 8'h03);
    wr(LSEL, 8'h00);
    wr(PSEL, 8'h09);
    lk8(2, 8'h05, UC, 4'h9);
    wr(LSEL, 16'h0102);
    wr(PSEL, 8'h0A);
    lk8(2, 8'h05, UC, 4'hA);
    lk8(1, 8'h05, UC, 4'h9);
    wr(LSEL, 8'h00);
    wr(DOM, 8'h12);
    rd(DOM, 8'h12);
    wr(DSEL, 16'h3400);
    wr(PSEL, 8'h41);
    rd(PSEL, 8'h41);
    lk16(0, 16'h3405, MC, 4'h1);
    lk16(0, 16'h1205, UC, 4'h9);
    lk16(0, 16'h0005, UC, 4'h9);
    lk8(0, 16'h3405, UC, 4'h9);
    look(0, 2'h2, 9'h000, 8'h05, DS, 4'h0);
    wr(DSEL, 16'h5600);
    wr(PSEL, 8'hDD);
    lk16(4, 16'h5605, UC, 4'h9);
    wr(DSEL, 8'h07);
    wr(PSEL, 8'hDF);
    lk8(3, 8'h07, DS, 4'h0);
    wr(DSEL, 8'h06);
    wr(PSEL, 8'h0F);
    lk8(3, 8'h06, UC, 4'hF);
    wr(`RTB_OFS_DEF_PORT, 8'h04);
    lk8(3, 8'h08, UC, 4'h4);
    look(1, 2'h0, 9'h103, 8'h05, UC, 4'h9);
    look(1, 2'h0, 9'h100, 8'h05, TM, 4'h0);
    wr(DSEL, 8'hFE);
    wr(PSEL, 32'h0403_0201, 1'b1);
    for (int i = 0; i < 4; i++)
      lk8(i, 8'(8'hFE + i), UC, 4'(i + 1));
    lk16(0, 16'h0100, UC, 4'h4);
    wr(DSEL, 16'h3300);
    wr(PSEL, 32'h0807_0605, 1'b1);
    lk16(0, 16'h3300, UC, 4'h5);
    lk16(0, 16'h3400, MC, 4'h1);
    lk8(0, 8'h00, UC, 4'h3);
    rd(24'h00_0100, 8'h00);
    wr(24'hE1_3080, 8'h0C);
    rd(24'hE1_3080, 8'h0C);
    lk8(3, 8'h20, UC, 4'hC);
    lk8(4, 8'h20, UC, 4'h4);
    wr(24'hE0_0024, 8'h0B);
    lk8(7, 8'h09, UC, 4'hB);
    close_out();
  end
endmodule
`default_nettype wire
